/* core/scs_top.sv */
`timescale 1ns/1ps
// How it works
// - Software picks the core system clock from the 8 MHz RC, the 48 MHz RC, the PLL or the external oscillator.
// - The PLL reference is one of the 8 MHz RC, the 48 MHz RC or the external oscillator.
// - A programmable multiplier and divider together set the PLL output rate.
// - Every reset selects the 8 MHz RC as system clock; software may switch afterwards.
// - A detected failure of the external oscillator moves the system clock to the 8 MHz RC by itself.
// - That failure raises an interrupt only when its enable is set.
// - The main bus clock is the system clock through a programmable divider.
// - Each peripheral bus clock is the main bus clock through its own programmable divider.
// - The 48 MHz RC is trimmed automatically against a sync input, with a manual offset on top.
// - Stop mode turns off the external oscillator, the 8 MHz RC and the PLL, keeping all registers.
module scs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tick_rc8,
  input wire logic tick_rc48,
  input wire logic tick_ext,
  input wire logic rdy_rc8,
  input wire logic rdy_rc48,
  input wire logic rdy_ext,
  input wire logic trim_sync,
  input wire logic stop_mode,
  output logic en_rc8,
  output logic en_rc48,
  output logic en_ext,
  output logic en_pll,
  output logic core_clk_en,
  output logic ahb_clk_en,
  output logic apb1_clk_en,
  output logic apb2_clk_en,
  output logic [7:0] rc48_trim,
  output logic irq
);
  import scs_pkg::*;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [23:0] cfg;
    logic [2:0] int_sts;
    logic [2:0] int_en;
    logic [8:0] trim_cfg;
    logic [1:0] act;
    scs_state_e st;
    logic ext_fail;
    logic [8:0] fail_cnt;
    logic [4:0] lock_cnt;
    logic pll_lock;
    logic [6:0] pll_acc;
    logic pll_tick;
    logic core_en;
    logic [3:0] osc_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } scs_top_s;

  scs_top_s s_q;
  scs_top_s s_d;
  logic [7:0] trim_val;
  logic trim_evt;
  logic ahb_en;
  logic apb1_en;
  logic apb2_en;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Picks one of four per-source bits by source code
  function automatic logic src_pick(input logic [1:0] sel, input logic [3:0] v);
    src_pick = v[sel];
  endfunction : src_pick

  // Picks the PLL reference bit; the spare code falls back to the 8 MHz RC
  function automatic logic ref_pick(input logic [1:0] sel, input logic [2:0] v);
    ref_pick = (sel == REF_RC48) ? v[1] : ((sel == REF_EXT) ? v[2] : v[0]);
  endfunction : ref_pick

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_CFG) || (a == OFS_STAT) || (a == OFS_INT_STS) ||
             (a == OFS_INT_EN) || (a == OFS_INT_CLR) || (a == OFS_TRIM);
  endfunction : mapped

  // ---------------------------------------------------------------
  // Combined next-state logic
  // ---------------------------------------------------------------
  logic [1:0] sel;
  logic [1:0] pref;
  logic [3:0] mul;
  logic [4:0] pdiv;
  logic ext_ok;
  logic ref_tick;
  logic ref_rdy;
  logic [3:0] ticks;
  logic [3:0] rdys;
  logic [2:0] int_set;
  logic [2:0] int_clr;
  logic wr;
  logic [7:0] acc_n;

  always_comb begin
    s_d = s_q;
    sel = s_q.cfg[CFG_SYS_SEL +: 2];
    pref = s_q.cfg[CFG_PLL_REF +: 2];
    mul = (s_q.cfg[CFG_PLL_MUL +: 4] > PLL_MUL_MAX) ? PLL_MUL_MAX : s_q.cfg[CFG_PLL_MUL +: 4];
    pdiv = {1'b0, s_q.cfg[CFG_PLL_DIV +: 4]} + 5'd1;
    ext_ok = rdy_ext && !s_q.ext_fail;
    int_set = 3'h0;
    int_clr = 3'h0;
    wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // Oscillator enables, all but the 48 MHz RC gated off in stop mode; registers keep their values
    s_d.osc_en[0] = !stop_mode;
    s_d.osc_en[1] = s_q.ctrl[CTRL_RC48_EN];
    s_d.osc_en[2] = s_q.ctrl[CTRL_EXT_EN] && !stop_mode;
    s_d.osc_en[3] = s_q.ctrl[CTRL_PLL_EN] && !stop_mode;

    // PLL reference and rate accumulator: ref * (mul + 2) / (div + 1)
    ref_tick = ref_pick(pref, {tick_ext && ext_ok, tick_rc48, tick_rc8});
    ref_rdy = ref_pick(pref, {ext_ok, rdy_rc48, rdy_rc8});
    // Output saturates at one tick per pclk; the accumulator is clamped
    acc_n = {1'b0, s_q.pll_acc} + (ref_tick ? {4'h0, mul} + 8'd2 : 8'd0);
    s_d.pll_tick = 1'b0;
    if (!s_q.osc_en[3] || !s_q.pll_lock) begin
      s_d.pll_acc = 7'h0;
    end else begin
      if (acc_n >= {3'h0, pdiv}) begin
        s_d.pll_tick = 1'b1;
        acc_n = acc_n - {3'h0, pdiv};
      end
      s_d.pll_acc = (acc_n > 8'd64) ? 7'd64 : acc_n[6:0];
    end

    // Lock after a fixed number of reference ticks
    if (!s_q.osc_en[3] || !ref_rdy) begin
      s_d.lock_cnt = 5'h0;
      s_d.pll_lock = 1'b0;
    end else if (ref_tick && !s_q.pll_lock) begin
      s_d.lock_cnt = s_q.lock_cnt + 5'h1;
      if (s_q.lock_cnt + 5'h1 == PLL_LOCK_TICKS) begin
        s_d.pll_lock = 1'b1;
        int_set[INT_PLL_LOCK] = 1'b1;
      end
    end

    // External oscillator watchdog: too long without a tick is a failure
    if (!s_q.ctrl[CTRL_EXT_EN]) begin
      s_d.ext_fail = 1'b0;
      s_d.fail_cnt = 9'h0;
    end else if (tick_ext || !rdy_ext || !s_q.ctrl[CTRL_FAIL_DET_EN]) begin
      s_d.fail_cnt = 9'h0;
    end else if (!s_q.ext_fail && !stop_mode) begin
      s_d.fail_cnt = s_q.fail_cnt + 9'h1;
      if (s_q.fail_cnt == 9'(FAIL_CYC - 1)) begin
        s_d.ext_fail = 1'b1;
        int_set[INT_EXT_FAIL] = 1'b1;
      end
    end

    // Source tick and ready vectors indexed by source code
    ticks = {tick_ext && ext_ok, s_q.pll_tick, tick_rc48, tick_rc8};
    rdys = {ext_ok, s_q.pll_lock, rdy_rc48, rdy_rc8};

    // Switch sequence: wait for the new source, then hand over right after an old tick
    s_d.core_en = src_pick(s_q.act, ticks);
    case (s_q.st)
      SCS_ST_RUN: begin
        if (sel != s_q.act) begin
          s_d.st = SCS_ST_WAIT;
        end
      end
      SCS_ST_WAIT: begin
        if (sel == s_q.act) begin
          s_d.st = SCS_ST_RUN;
        end else if (src_pick(sel, rdys)) begin
          s_d.st = SCS_ST_HOLD;
        end
      end
      SCS_ST_HOLD: begin
        // Cutting over just after an old pulse keeps every pulse whole
        if (src_pick(s_q.act, ticks) || !src_pick(s_q.act, rdys)) begin
          s_d.act = sel;
          s_d.st = SCS_ST_RUN;
        end else if (!src_pick(sel, rdys)) begin
          s_d.st = SCS_ST_WAIT;
        end
      end
      default: begin
        s_d.st = SCS_ST_RUN;
      end
    endcase

    // Failure fallback overrides any switch in flight
    if (int_set[INT_EXT_FAIL] && (s_q.act == SRC_EXT || (s_q.act == SRC_PLL && pref == REF_EXT))) begin
      s_d.act = SRC_RC8;
      s_d.st = SCS_ST_RUN;
      s_d.core_en = 1'b0;
    end

    // APB setup phase: prepare read data and answer in the access phase
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !mapped(paddr);
      case (paddr)
        OFS_CTRL: s_d.prdata = {28'h0, s_q.ctrl};
        OFS_CFG: s_d.prdata = {8'h0, s_q.cfg};
        OFS_STAT: s_d.prdata = {24'h0, rdy_rc48, rdy_rc8, ext_ok, s_q.ext_fail, s_q.pll_lock,
                                s_q.st != SCS_ST_RUN, s_q.act};
        OFS_INT_STS: s_d.prdata = {29'h0, s_q.int_sts};
        OFS_INT_EN: s_d.prdata = {29'h0, s_q.int_en};
        OFS_TRIM: s_d.prdata = {8'h0, trim_val, 7'h0, s_q.trim_cfg};
        default: s_d.prdata = 32'h0;
      endcase
    end

    // APB access phase writes
    if (wr) begin
      case (paddr)
        OFS_CTRL: s_d.ctrl = pwdata[3:0];
        OFS_CFG: begin
          s_d.cfg = pwdata[23:0];
          // Failover is sticky: no return to a failed external source
          if (s_q.ext_fail && pwdata[CFG_SYS_SEL +: 2] == SRC_EXT) begin
            s_d.cfg[CFG_SYS_SEL +: 2] = SRC_RC8;
          end
        end
        OFS_INT_EN: s_d.int_en = pwdata[2:0];
        OFS_INT_CLR: int_clr = pwdata[2:0];
        OFS_TRIM: s_d.trim_cfg = pwdata[8:0];
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    if (int_set[INT_EXT_FAIL] && sel == SRC_EXT) begin
      s_d.cfg[CFG_SYS_SEL +: 2] = SRC_RC8;
    end

    // Sticky status: a set in the same cycle as a clear wins
    int_set[INT_TRIM_SYNC] = trim_evt;
    s_d.int_sts = (s_q.int_sts & ~int_clr) | int_set;
    s_d.irq = |(s_q.int_sts & s_q.int_en);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.cfg <= CFG_RST;
      s_q.int_en <= INT_EN_RST;
      s_q.trim_cfg <= TRIM_CFG_RST;
      s_q.act <= SRC_RC8;
      s_q.st <= SCS_ST_RUN;
      s_q.osc_en <= 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Bus clock dividers and trim unit
  // ---------------------------------------------------------------
  scs_div u_ahb_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(s_q.core_en),
    .div(s_q.cfg[CFG_AHB_DIV +: 4]),
    .tick_out(ahb_en)
  );

  scs_div u_apb1_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ahb_en),
    .div(s_q.cfg[CFG_APB1_DIV +: 4]),
    .tick_out(apb1_en)
  );

  scs_div u_apb2_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ahb_en),
    .div(s_q.cfg[CFG_APB2_DIV +: 4]),
    .tick_out(apb2_en)
  );

  scs_trim u_trim (
    .pclk(pclk),
    .presetn(presetn),
    .tick_48(tick_rc48),
    .sync_in(trim_sync),
    .auto_en(s_q.trim_cfg[TRIM_AUTO_EN]),
    .manual(s_q.trim_cfg[TRIM_MANUAL +: 8]),
    .trim_out(trim_val),
    .sync_evt(trim_evt)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign en_rc8 = s_q.osc_en[0];
  assign en_rc48 = s_q.osc_en[1];
  assign en_ext = s_q.osc_en[2];
  assign en_pll = s_q.osc_en[3];
  assign core_clk_en = s_q.core_en;
  assign ahb_clk_en = ahb_en;
  assign apb1_clk_en = apb1_en;
  assign apb2_clk_en = apb2_en;
  assign rc48_trim = trim_val;
  assign irq = s_q.irq;

endmodule : scs_top

/* include/scs_pkg.sv */
package scs_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_STS = 8'h0c;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_INT_CLR = 8'h14;
  localparam logic [7:0] OFS_TRIM = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_RC48_EN = 1;
  localparam int CTRL_PLL_EN = 2;
  localparam int CTRL_FAIL_DET_EN = 3;
  localparam int CFG_SYS_SEL = 0;
  localparam int CFG_PLL_REF = 2;
  localparam int CFG_PLL_MUL = 4;
  localparam int CFG_PLL_DIV = 8;
  localparam int CFG_AHB_DIV = 12;
  localparam int CFG_APB1_DIV = 16;
  localparam int CFG_APB2_DIV = 20;
  localparam int INT_EXT_FAIL = 0;
  localparam int INT_PLL_LOCK = 1;
  localparam int INT_TRIM_SYNC = 2;
  localparam int TRIM_MANUAL = 0;
  localparam int TRIM_AUTO_EN = 8;
  localparam int TRIM_VALUE = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [23:0] CFG_RST = 24'h000000;
  localparam logic [2:0] INT_EN_RST = 3'h0;
  localparam logic [8:0] TRIM_CFG_RST = 9'h000;
  localparam logic [7:0] TRIM_BASE_RST = 8'h40;

  // ---------------------------------------------------------------
  // Clock source codes and switch states
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_RC8 = 2'h0;
  localparam logic [1:0] SRC_RC48 = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [1:0] REF_RC8 = 2'h0;
  localparam logic [1:0] REF_RC48 = 2'h1;
  localparam logic [1:0] REF_EXT = 2'h2;
  localparam logic [3:0] PLL_MUL_MAX = 4'he;

  typedef enum logic [1:0] {SCS_ST_RUN, SCS_ST_WAIT, SCS_ST_HOLD} scs_state_e;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FAIL_NS = 1000;
  localparam int FAIL_CYC = (FAIL_NS * CLK_MHZ) / 1000;
  localparam logic [4:0] PLL_LOCK_TICKS = 5'd16;
  localparam logic [15:0] TRIM_EXPECT = 16'd48000;
  localparam logic [15:0] TRIM_TOL = 16'd24;

endpackage : scs_pkg

/* core/scs_div.sv */
`timescale 1ns/1ps
// Divides a stream of one-cycle ticks by (div + 1)
module scs_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [3:0] div,
  output logic tick_out
);
  import scs_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic out;
  } scs_div_s;

  scs_div_s s_q;
  scs_div_s s_d;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // A new ratio takes effect at once; a count at or past it wraps on the next input tick
  always_comb begin
    s_d = s_q;
    s_d.out = 1'b0;
    if (tick_in) begin
      if (s_q.cnt >= div) begin
        s_d.cnt = 4'h0;
        s_d.out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.out;

endmodule : scs_div

/* core/scs_trim.sv */
`timescale 1ns/1ps
// Trims the fast internal oscillator against a sync pulse
module scs_trim (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_48,
  input wire logic sync_in,
  input wire logic auto_en,
  input wire logic [7:0] manual,
  output logic [7:0] trim_out,
  output logic sync_evt
);
  import scs_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] base;
    logic [7:0] out;
    logic evt;
  } scs_trim_s;

  scs_trim_s s_q;
  scs_trim_s s_d;

  // ---------------------------------------------------------------
  // Tick count per sync window, step trim up or down
  // ---------------------------------------------------------------
  // Manual offset adds on top, so software can start near target
  always_comb begin
    s_d = s_q;
    s_d.evt = 1'b0;
    if (tick_48 && s_q.cnt != 16'hffff) begin
      s_d.cnt = s_q.cnt + 16'h1;
    end
    if (sync_in) begin
      s_d.cnt = 16'h0;
      s_d.evt = 1'b1;
      if (auto_en) begin
        if (s_q.cnt < TRIM_EXPECT - TRIM_TOL && s_q.base != 8'hff) begin
          s_d.base = s_q.base + 8'h1;
        end else if (s_q.cnt > TRIM_EXPECT + TRIM_TOL && s_q.base != 8'h00) begin
          s_d.base = s_q.base - 8'h1;
        end
      end
    end
    s_d.out = s_q.base + manual;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.base <= TRIM_BASE_RST;
      s_q.out <= TRIM_BASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign trim_out = s_q.out;
  assign sync_evt = s_q.evt;

endmodule : scs_trim

/* tb/scs_asserts.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Bus handshake and clock tree checks
// ---------------------------------------------
module scs_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic en_rc8,
  input wire logic en_ext,
  input wire logic en_pll,
  input wire logic core_clk_en,
  input wire logic ahb_clk_en,
  input wire logic apb1_clk_en,
  input wire logic apb2_clk_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Two steps of one bus transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  // Bus answers in the first access cycle and only there
  ready_follows_a: assert property (setup_s ##1 access_s |-> pready) else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_access_a: assert property (pready |-> access_s) else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad error data");

  // Stop mode gates the slow-start oscillators; the 8 MHz RC runs otherwise
  stop_gates_a: assert property (stop_mode |=> !en_rc8 && !en_ext && !en_pll) else $error("stop left on");
  rc8_runs_a: assert property (!stop_mode |=> en_rc8) else $error("rc8 fallback off");

  // A bus tick needs a parent tick now or one cycle back (divider may register)
  ahb_from_core_a: assert property (ahb_clk_en |-> core_clk_en || $past(core_clk_en)) else $error("ahb tick alone");
  apb1_from_ahb_a: assert property (apb1_clk_en |-> ahb_clk_en || $past(ahb_clk_en)) else $error("apb1 tick alone");
  apb2_from_ahb_a: assert property (apb2_clk_en |-> ahb_clk_en || $past(ahb_clk_en)) else $error("apb2 tick alone");
endmodule : scs_asserts

bind scs_top scs_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
  .en_rc8(en_rc8), .en_ext(en_ext), .en_pll(en_pll), .core_clk_en(core_clk_en),
  .ahb_clk_en(ahb_clk_en), .apb1_clk_en(apb1_clk_en), .apb2_clk_en(apb2_clk_en));

/* tb/system_clock_selector_tb.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Self-checking bench for the clock selector
// ---------------------------------------------
module system_clock_selector_tb;
  import scs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cfg_w;
  logic pready, pslverr, err, irq;
  logic tick_rc8 = 0, tick_rc48 = 0, tick_ext = 0, rdy_rc8 = 1, rdy_rc48 = 1, rdy_ext = 1;
  logic trim_sync = 0, stop_mode = 0, ext_on = 1;
  logic en_rc8, en_rc48, en_ext, en_pll, core_clk_en, ahb_clk_en, apb1_clk_en, apb2_clk_en;
  logic [7:0] rc48_trim;
  logic [3:0] dv [3] = '{default: 4'h0};
  logic [3:0] pm = 4'h3, pd = 4'h0;
  int seed = 32'h8564;
  int fail_count = 0, num_checks = 0, ca, c1, c2, cc;

  scs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_rc8(tick_rc8), .tick_rc48(tick_rc48), .tick_ext(tick_ext), .rdy_rc8(rdy_rc8),
    .rdy_rc48(rdy_rc48), .rdy_ext(rdy_ext), .trim_sync(trim_sync), .stop_mode(stop_mode),
    .en_rc8(en_rc8), .en_rc48(en_rc48), .en_ext(en_ext), .en_pll(en_pll), .core_clk_en(core_clk_en),
    .ahb_clk_en(ahb_clk_en), .apb1_clk_en(apb1_clk_en), .apb2_clk_en(apb2_clk_en),
    .rc48_trim(rc48_trim), .irq(irq));

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // Oscillator ticks; the fast RC ticks every cycle so bus counts are exact
  always @(posedge pclk) begin
    tick_rc8 <= 1'($random(seed));
    tick_rc48 <= 1'b1;
    tick_ext <= ext_on & 1'($random(seed));
    trim_sync <= ($random(seed) % 600) == 0;
  end

  task results;
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task ck(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : ck

  task ok(input logic c);
    ck({31'h0, c}, 32'h1);
  endtask : ok

  function automatic logic near(input int c, input int e, input int t);
    return (c >= e - t) && (c <= e + t);
  endfunction : near

  // One transfer; idle cycle first so no signal is driven twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck(rd & m, e);
  endtask : rdck

  // Bounded poll of a register field, then compare
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 100);
    ck(rd & m, e);
  endtask : poll

  task cfg(input logic [1:0] s, input logic [1:0] f);
    cfg_w = {8'h00, dv[2], dv[1], dv[0], pd, pm, f, s};
    apb(1'b1, OFS_CFG, cfg_w);
  endtask : cfg

  // Watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ok(en_rc8 === 1'b1);
    ck({24'h0, rc48_trim}, 32'h40);
    rdck(OFS_STAT, 32'h3, 32'h0);
    rdck(OFS_CFG, 32'hffffffff, 32'h0);
    apb(1'b1, 8'h1c, 32'hffffffff);
    ok(err === 1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    ck({err, rd[30:0]}, 32'h80000000);
    rdck(OFS_INT_CLR, 32'hffffffff, 32'h0);
    apb(1'b1, OFS_TRIM, 32'h5);
    repeat (2) @(posedge pclk);
    ck({24'h0, rc48_trim}, 32'h45);
    // PLL not running: request must wait
    cfg(SRC_PLL, REF_RC8);
    repeat (10) @(posedge pclk);
    rdck(OFS_STAT, 32'h7, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h7);
    poll(OFS_STAT, 32'h3, 32'h2);
    for (int i = 0; i < 3; i++) begin
      cfg(SRC_RC8, 2'(i));
      poll(OFS_STAT, 32'h8, 32'h8);
    end
    for (int s = 1; s < 5; s++) begin
      cfg(2'(s), REF_EXT);
      poll(OFS_STAT, 32'h3, 32'(s % 4));
    end
    // Bus dividers: maximum first, then random
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) dv[k] = (r == 0) ? 4'hf : 4'($random(seed));
      cfg(SRC_RC48, REF_RC48);
      repeat (20) @(posedge pclk);
      ca = 0;
      c1 = 0;
      c2 = 0;
      cc = 0;
      repeat (1024) begin
        @(posedge pclk);
        cc += int'(core_clk_en === 1'b1);
        ca += int'(ahb_clk_en === 1'b1);
        c1 += int'(apb1_clk_en === 1'b1);
        c2 += int'(apb2_clk_en === 1'b1);
      end
      ok(cc == 1024);
      ok(near(ca, 1024 / (int'(dv[0]) + 1), 1));
      ok(near(c1, 1024 / ((int'(dv[0]) + 1) * (int'(dv[1]) + 1)), 2));
      ok(near(c2, 1024 / ((int'(dv[0]) + 1) * (int'(dv[2]) + 1)), 2));
    end
    // PLL on the 8 MHz RC, factor 2 over 8: a quarter of the reference ticks
    pm = 4'h0;
    pd = 4'h7;
    cfg(SRC_PLL, REF_RC8);
    poll(OFS_STAT, 32'h3, 32'h2);
    repeat (20) @(posedge pclk);
    cc = 0;
    c1 = 0;
    repeat (1024) begin
      @(posedge pclk);
      cc += int'(core_clk_en === 1'b1);
      c1 += int'(tick_rc8 === 1'b1);
    end
    ok(near(cc, (c1 * (int'(pm) + 2)) / (int'(pd) + 1), 2));
    // External oscillator dies while it drives the system
    apb(1'b1, OFS_INT_EN, 32'h1);
    apb(1'b1, OFS_CTRL, 32'hb);
    cfg(SRC_EXT, REF_RC48);
    poll(OFS_STAT, 32'h3, 32'h3);
    ext_on <= 1'b0;
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge pclk);
    ok(irq === 1'b1);
    rdck(OFS_STAT, 32'h13, 32'h10);
    rdck(OFS_INT_STS, 32'h1, 32'h1);
    apb(1'b1, OFS_INT_EN, 32'h0);
    repeat (2) @(posedge pclk);
    ok(irq === 1'b0);
    apb(1'b1, OFS_CTRL, 32'h6);
    apb(1'b1, OFS_INT_CLR, 32'h7);
    rdck(OFS_INT_STS, 32'h1, 32'h0);
    ext_on <= 1'b1;
    // Stop mode gates oscillators, keeps settings
    apb(1'b1, OFS_CTRL, 32'h7);
    repeat (2) @(posedge pclk);
    ck({28'h0, en_rc8, en_rc48, en_ext, en_pll}, 32'hf);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    ck({28'h0, en_rc8, en_rc48, en_ext, en_pll}, 32'h4);
    rdck(OFS_CFG, 32'hfffffc, cfg_w & 32'hfffffc);
    stop_mode <= 1'b0;
    // Automatic trim pulls the short count up
    apb(1'b1, OFS_TRIM, 32'h105);
    // Sync comes about once in 600 cycles; a long wait keeps a late pulse from failing
    for (int i = 0; i < 8000 && rc48_trim <= 8'h45; i++) @(posedge pclk);
    ok(rc48_trim > 8'h45);
    // Reset in mid-run returns to the 8 MHz RC
    cfg(SRC_RC48, REF_RC48);
    poll(OFS_STAT, 32'h3, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdck(OFS_STAT, 32'h3, 32'h0);
    results();
  end
endmodule : system_clock_selector_tb
